// ==== sfc_serial_port.sv ====
// serial port: format and control registers, transmitter, receiver, avalon slave
// Overview of operation
// RL1 - char length select 1 gives 7-bit characters, bit 7 dropped; 0 gives 8 bits
// RL2 - parity added and checked only in asynchronous mode with parity on
// RL3 - odd select 0: even count of ones in character plus parity
// RL4 - odd select 1: odd count of ones in character plus parity
// RL5 - asynchronous transmit appends one stop bit, or two when stop select is 1
// RL6 - receiver checks only the first stop bit; a following 0 starts a character
// RL7 - clocked synchronous mode sends no stop bits; stop select ignored
// RL8 - address format only in asynchronous mode, and it overrides parity settings
// RL9 - prescale select picks clk, clk/4, clk/16 or clk/64 for the rate generator
// RL10 - control register clears on reset, standby or module stop; else read/write
// RL11 - tx-empty request raised while enabled and holding-empty flag is 1
// RL12 - tx-empty request drops on flag cleared after read, or enable cleared
// RL13 - rx-full and rx-error requests raised when enabled and data reaches holding
// RL14 - rx requests drop when flags cleared after read, or enable cleared
// RL15 - transmit off holds holding-empty at 1 and starts nothing
// RL16 - transmit on starts sending once holding-empty is cleared to 0
// RL17 - software sets the format before turning transmit or receive on
// RL18 - turning receive off leaves full, framing, parity and overrun flags alone
// RL19 - receiver starts on start bit (async) or serial clock edge (sync)
// RL20 - address wake enable works only in asynchronous address format
// RL21 - mode select 0 is asynchronous, 1 is clocked synchronous
// RL22 - clocked synchronous mode always uses 8-bit characters
// RL23 - parity or address bit sits after data and before the stop bits
//
// Added by the designer: the Avalon-MM register port and the register addresses.
`timescale 1ns/1ps
module sfc_serial_port import sfc_pkg::*; (
	input wire logic clk_sys_in,
	input wire logic rst_in,
	input wire logic low_power_in,
	input wire logic [ADDR_W-1:0] avs_address_in,
	input wire logic avs_read_in,
	input wire logic avs_write_in,
	input wire logic [31:0] avs_writedata_in,
	input wire logic [3:0] avs_byteenable_in,
	output logic [31:0] avs_readdata_out,
	output logic avs_waitrequest_out,
	input wire logic rxd_in,
	output logic txd_out,
	input wire logic sck_pin_in,
	output logic sck_pin_out,
	output logic sck_pin_oe_out,
	output logic tx_empty_irq_out,
	output logic rx_full_irq_out,
	output logic rx_error_irq_out
);
	sfc_state_t q;
	sfc_state_t d;
	logic ps_tick;
	logic samp;
	logic req;
	logic wr;
	logic rd;
	logic [3:0] nd;
	logic ext;
	logic addr_fmt;
	logic xbit;
	logic [7:0] dm;
	logic [11:0] frame;
	logic [3:0] tx_count;
	logic run;
	logic sck_rise;
	logic sck_fall;
	logic [3:0] rx_need;
	logic [9:0] rx_shv;
	logic [9:0] word;
	logic [7:0] rx_data;
	logic rx_xb;
	logic rx_stop;
	logic rx_done;
	logic tx_done;

	sfc_prescaler u_ps (
		.clk_sys_in(clk_sys_in),
		.rst_in(rst_in),
		.sel_in({q.fmt.prescale_sel_hi, q.fmt.prescale_sel_lo}),
		.tick_out(ps_tick)
	);

	sfc_rate_gen #(.CNT_W(8)) u_rate (
		.clk_sys_in(clk_sys_in),
		.rst_in(rst_in),
		.tick_in(ps_tick),
		.rate_in(q.rate),
		.samp_out(samp)
	);

	////////////////////////////////////////////////////////////////////////////////
	always_comb begin
		d = q;
		rx_done = 1'b0;
		tx_done = 1'b0;
		nd = sfc_data_len(q.fmt); // [RL1] [RL22]
		ext = sfc_has_extra(q.fmt); // [RL2] [RL8]
		addr_fmt = !q.fmt.sync_mode && q.fmt.addressed_frame_format; // [RL8] [RL21]

		// bus: every access outside standby or module stop waits exactly one cycle, data registered meanwhile
		req = avs_read_in || avs_write_in;
		d.waitreq = !(req && q.waitreq);
		rd = avs_read_in && !q.waitreq;
		wr = avs_write_in && !q.waitreq && avs_byteenable_in[0];
		d.rdata = '0;
		if (req && q.waitreq) begin
			case (avs_address_in)
				OFS_FMT: d.rdata[7:0] = q.fmt;
				OFS_RATE: d.rdata[7:0] = q.rate;
				OFS_CTL: d.rdata[7:0] = q.ctl;
				OFS_TXH: d.rdata[7:0] = q.txh;
				OFS_FLAGS: d.rdata[7:0] = q.flags;
				OFS_RXH: d.rdata[7:0] = q.rxh;
				default: d.rdata = '0;
			endcase
		end
		if (rd && avs_address_in == OFS_FLAGS) begin
			d.armed = q.flags;
		end
		if (wr) begin
			case (avs_address_in)
				OFS_FMT: d.fmt = avs_writedata_in[7:0];
				OFS_RATE: d.rate = avs_writedata_in[7:0];
				OFS_CTL: d.ctl = avs_writedata_in[7:0]; // [RL10]
				OFS_TXH: d.txh = avs_writedata_in[7:0];
				OFS_FLAGS: begin
					// a flag clears only on 0 written after it was read as 1
					d.flags[7:3] = q.flags[7:3] & (avs_writedata_in[7:3] | ~q.armed[7:3]); // [RL12] [RL14]
					d.flags.mp_bit_tx = avs_writedata_in[0];
					d.armed = '0;
				end
				default: d.armed = d.armed;
			endcase
		end

		// serial clock for synchronous mode: output from rate generator or pin input
		run = q.tx_busy || (q.ctl.rx_on && !q.flags.rx_holding_full);
		sck_rise = 1'b0;
		sck_fall = 1'b0;
		d.sck_prev = sck_pin_in;
		d.sck_oe = q.fmt.sync_mode && !q.ctl.clock_pin_sel_hi;
		if (q.fmt.sync_mode && q.ctl.clock_pin_sel_hi) begin
			sck_rise = sck_pin_in && !q.sck_prev;
			sck_fall = !sck_pin_in && q.sck_prev;
		end else if (q.fmt.sync_mode && samp && (run || !q.sck)) begin
			sck_fall = q.sck;
			sck_rise = !q.sck;
			d.sck = !q.sck;
		end else if (!q.fmt.sync_mode) begin
			d.sck = 1'b1;
		end

		////////////////////////////////////////////////////////////////////////////////
		// transmitter
		dm = (nd == ASYNC_BITS7) ? (q.txh & DATA7_MASK) : q.txh; // [RL1]
		xbit = addr_fmt ? q.flags.mp_bit_tx : (^dm ^ q.fmt.odd_parity_sel); // [RL3] [RL4]
		frame = {3'h7, (nd == ASYNC_BITS7) | q.txh[7], q.txh[6:0], 1'b0};
		if (ext) begin
			frame[4'(nd + 4'h1)] = xbit; // [RL23]
		end
		tx_count = 4'h1 + nd + {3'h0, ext} + (q.fmt.stop_sel ? 4'h2 : 4'h1); // [RL5]
		if (!q.tx_busy && q.ctl.tx_on && !q.flags.tx_holding_empty) begin
			d.tx_busy = 1'b1; // [RL16]
			d.flags.tx_holding_empty = 1'b1; // [RL11]
			d.flags.tx_end = 1'b0;
			d.tx_tick = '0;
			if (q.fmt.sync_mode) begin
				d.tx_sh = {4'hf, q.txh};
				d.tx_left = SYNC_BITS; // [RL7] [RL22]
			end else begin
				d.tx_sh = {1'b1, frame[11:1]};
				d.txd = frame[0];
				d.tx_left = tx_count;
			end
		end else if (q.tx_busy && q.fmt.sync_mode) begin
			if (sck_fall) begin
				d.txd = q.tx_sh[0];
				d.tx_sh = {1'b1, q.tx_sh[11:1]};
			end
			if (sck_rise) begin
				d.tx_left = q.tx_left - 4'h1;
				tx_done = (q.tx_left == 4'h1);
			end
		end else if (q.tx_busy && samp) begin
			d.tx_tick = q.tx_tick + 4'h1;
			if (q.tx_tick == OVS_LAST) begin
				if (q.tx_left == 4'h1) begin
					tx_done = 1'b1;
				end else begin
					d.txd = q.tx_sh[0];
					d.tx_sh = {1'b1, q.tx_sh[11:1]};
					d.tx_left = q.tx_left - 4'h1;
				end
			end
		end
		if (tx_done) begin
			d.tx_busy = 1'b0;
			// clocked frames hold the last bit past its rising clock edge, no zero hold
			if (!q.fmt.sync_mode) begin
				d.txd = 1'b1;
			end
			d.flags.tx_end = q.flags.tx_holding_empty;
		end
		// transmit off: abort the frame, line idles high
		if (!q.ctl.tx_on) begin
			d.tx_busy = 1'b0;
			d.txd = 1'b1;
			d.flags.tx_holding_empty = 1'b1; // [RL15]
		end

		////////////////////////////////////////////////////////////////////////////////
		// receiver; only the first stop bit is sampled
		rx_need = q.fmt.sync_mode ? SYNC_BITS : (nd + {3'h0, ext} + 4'h1); // [RL6]
		rx_shv = {rxd_in, q.rx_sh[9:1]};
		case (q.rx_st)
			RX_IDLE: begin
				if (q.ctl.rx_on && !q.fmt.sync_mode && !rxd_in) begin
					d.rx_st = RX_START; // [RL19]
					d.rx_tick = '0;
				end else if (q.ctl.rx_on && q.fmt.sync_mode && sck_rise) begin
					d.rx_sh = rx_shv; // [RL19]
					d.rx_cnt = 4'h1;
					d.rx_st = RX_BITS;
				end
			end
			RX_START: begin
				if (samp) begin
					d.rx_tick = q.rx_tick + 4'h1;
					if (q.rx_tick == OVS_MID) begin
						// a glitch shorter than half a bit is not a start bit
						d.rx_st = rxd_in ? RX_IDLE : RX_BITS;
						d.rx_tick = '0;
						d.rx_cnt = '0;
					end
				end
			end
			RX_BITS: begin
				if (q.fmt.sync_mode ? sck_rise : (samp && q.rx_tick == OVS_LAST)) begin
					d.rx_sh = rx_shv;
					d.rx_cnt = q.rx_cnt + 4'h1;
					rx_done = (q.rx_cnt + 4'h1 == rx_need);
				end
				if (samp && !q.fmt.sync_mode) begin
					d.rx_tick = q.rx_tick + 4'h1;
				end
			end
			default: d.rx_st = RX_IDLE;
		endcase

		word = rx_shv >> (RX_SH_LEN - rx_need);
		rx_data = (nd == ASYNC_BITS7) ? (word[7:0] & DATA7_MASK) : word[7:0]; // [RL1]
		rx_xb = word[nd];
		rx_stop = word[nd + {3'h0, ext}];
		if (rx_done) begin
			d.rx_st = RX_IDLE;
			if (addr_fmt) begin
				d.flags.mp_bit_rx = rx_xb;
			end
			if (!(addr_fmt && q.ctl.addr_wake_irq_on && !rx_xb)) begin // [RL20]
				if (addr_fmt && rx_xb) begin
					d.ctl.addr_wake_irq_on = 1'b0;
				end
				if (q.flags.rx_holding_full) begin
					d.flags.overrun_flag = 1'b1;
				end else begin
					d.rxh = rx_data;
					d.flags.rx_holding_full = 1'b1; // [RL13]
					if (!q.fmt.sync_mode && !rx_stop) begin
						d.flags.framing_err_flag = 1'b1; // [RL6]
					end
					if (ext && !addr_fmt && ((^rx_data ^ rx_xb) != q.fmt.odd_parity_sel)) begin
						d.flags.parity_err_flag = 1'b1; // [RL2] [RL3] [RL4]
					end
				end
			end
		end
		// receive off stops the engine; the flags keep their state
		if (!q.ctl.rx_on) begin
			d.rx_st = RX_IDLE; // [RL18]
		end

		// interrupt requests follow enables and flags
		d.irq_tx = q.ctl.tx_empty_irq_on && q.flags.tx_holding_empty; // [RL11] [RL12]
		d.irq_rx = q.ctl.rx_full_irq_on && q.flags.rx_holding_full; // [RL13] [RL14]
		d.irq_err = q.ctl.rx_full_irq_on
			&& (q.flags.framing_err_flag || q.flags.parity_err_flag || q.flags.overrun_flag); // [RL14]

		// standby or module stop: registers back to initial values, bus not answered
		if (low_power_in) begin
			d = sfc_state_reset(); // [RL10]
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			q <= sfc_state_reset(); // [RL10]
		end else begin
			q <= d;
		end
	end

	assign avs_readdata_out = q.rdata;
	assign avs_waitrequest_out = q.waitreq;
	assign txd_out = q.txd;
	assign sck_pin_out = q.sck;
	assign sck_pin_oe_out = q.sck_oe;
	assign tx_empty_irq_out = q.irq_tx;
	assign rx_full_irq_out = q.irq_rx;
	assign rx_error_irq_out = q.irq_err;

	////////////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge clk_sys_in);
	endclocking
	default disable iff (rst_in || low_power_in);

	chk_tx_off_empty: assert property (!q.ctl.tx_on |=> q.flags.tx_holding_empty && !q.tx_busy) // [RL15]
		else $error("holding-empty not forced while transmit off");
	chk_tx_start: assert property (q.ctl.tx_on && !q.flags.tx_holding_empty && !q.tx_busy
		&& !low_power_in ##1 q.ctl.tx_on |-> q.tx_busy) // [RL16]
		else $error("transmission did not start");
	chk_txe_request: assert property (q.ctl.tx_empty_irq_on && q.flags.tx_holding_empty
		|=> tx_empty_irq_out) // [RL11]
		else $error("tx-empty request missing");
	chk_txe_withdraw: assert property (!q.ctl.tx_empty_irq_on |=> !tx_empty_irq_out) // [RL12]
		else $error("tx-empty request not withdrawn");
	chk_rx_request: assert property ($rose(q.flags.rx_holding_full) && q.ctl.rx_full_irq_on
		|=> rx_full_irq_out) // [RL13]
		else $error("rx-full request missing");
	chk_rx_off_flags: assert property ($fell(q.ctl.rx_on) && !$past(rx_done)
		|-> q.flags[6:3] == $past(q.flags[6:3])) // [RL18]
		else $error("receive off changed receive flags");
	chk_sync_len: assert property ($rose(q.tx_busy) && $past(q.fmt.sync_mode)
		|-> q.tx_left == SYNC_BITS) // [RL7]
		else $error("synchronous frame length wrong");
	chk_async_len: assert property ($rose(q.tx_busy) && !$past(q.fmt.sync_mode)
		|-> q.tx_left == 4'h1 + sfc_data_len($past(q.fmt)) + {3'h0, sfc_has_extra($past(q.fmt))}
		+ ($past(q.fmt.stop_sel) ? 4'h2 : 4'h1) && !txd_out) // [RL5]
		else $error("asynchronous frame length or start bit wrong");
	chk_bus_answer: assert property ((avs_read_in || avs_write_in) && avs_waitrequest_out
		|=> !avs_waitrequest_out)
		else $error("bus access not answered in one cycle");

	cov_tx_frame: cover property ($fell(q.tx_busy) && q.ctl.tx_on);
	cov_rx_frame: cover property (rx_done && !q.fmt.sync_mode);
	cov_overrun: cover property ($rose(q.flags.overrun_flag));
	cov_sync_tx: cover property ($rose(q.tx_busy) && q.fmt.sync_mode);
endmodule : sfc_serial_port

// ==== sfc_pkg.sv ====
// shared constants, register layouts and state types of the serial format and control block
package sfc_pkg;
	localparam int ADDR_W = 5;
	localparam logic [4:0] OFS_FMT = 5'h00;
	localparam logic [4:0] OFS_RATE = 5'h04;
	localparam logic [4:0] OFS_CTL = 5'h08;
	localparam logic [4:0] OFS_TXH = 5'h0c;
	localparam logic [4:0] OFS_FLAGS = 5'h10;
	localparam logic [4:0] OFS_RXH = 5'h14;
	localparam logic [7:0] RATE_RST = 8'hff;
	localparam logic [7:0] TXH_RST = 8'hff;
	localparam logic [7:0] FLAGS_RST = 8'h84;
	localparam logic [7:0] DATA7_MASK = 8'h7f;
	localparam logic [3:0] OVS_LAST = 4'hf;
	localparam logic [3:0] OVS_MID = 4'h7;
	localparam logic [3:0] SYNC_BITS = 4'h8;
	localparam logic [3:0] ASYNC_BITS8 = 4'h8;
	localparam logic [3:0] ASYNC_BITS7 = 4'h7;
	localparam logic [3:0] RX_SH_LEN = 4'ha;
	localparam logic [5:0] PS_MASK_1 = 6'h00;
	localparam logic [5:0] PS_MASK_4 = 6'h03;
	localparam logic [5:0] PS_MASK_16 = 6'h0f;
	localparam logic [5:0] PS_MASK_64 = 6'h3f;

	typedef struct packed {
		logic sync_mode;
		logic char_len_select;
		logic parity_on;
		logic odd_parity_sel;
		logic stop_sel;
		logic addressed_frame_format;
		logic prescale_sel_hi;
		logic prescale_sel_lo;
	} sfc_fmt_t;

	typedef struct packed {
		logic tx_empty_irq_on;
		logic rx_full_irq_on;
		logic tx_on;
		logic rx_on;
		logic addr_wake_irq_on;
		logic tx_done_irq_on;
		logic clock_pin_sel_hi;
		logic clock_pin_sel_lo;
	} sfc_ctl_t;

	typedef struct packed {
		logic tx_holding_empty;
		logic rx_holding_full;
		logic overrun_flag;
		logic framing_err_flag;
		logic parity_err_flag;
		logic tx_end;
		logic mp_bit_rx;
		logic mp_bit_tx;
	} sfc_flags_t;

	typedef enum logic [1:0] {RX_IDLE, RX_START, RX_BITS} sfc_rx_t;

	typedef struct packed {
		sfc_fmt_t fmt;
		sfc_ctl_t ctl;
		sfc_flags_t flags;
		sfc_flags_t armed;
		logic [7:0] rate;
		logic [7:0] txh;
		logic [7:0] rxh;
		logic waitreq;
		logic [31:0] rdata;
		logic tx_busy;
		logic [11:0] tx_sh;
		logic [3:0] tx_left;
		logic [3:0] tx_tick;
		logic txd;
		sfc_rx_t rx_st;
		logic [9:0] rx_sh;
		logic [3:0] rx_cnt;
		logic [3:0] rx_tick;
		logic sck;
		logic sck_prev;
		logic sck_oe;
		logic irq_tx;
		logic irq_rx;
		logic irq_err;
	} sfc_state_t;

	function automatic sfc_state_t sfc_state_reset();
		sfc_state_t s;
		s = '0;
		s.rate = RATE_RST;
		s.txh = TXH_RST;
		s.flags = FLAGS_RST;
		s.txd = 1'b1;
		s.sck = 1'b1;
		s.sck_prev = 1'b1;
		s.waitreq = 1'b1;
		return s;
	endfunction : sfc_state_reset

	// data bits of one character; clocked synchronous frames are always 8 bits
	function automatic logic [3:0] sfc_data_len(input sfc_fmt_t f);
		if (f.sync_mode || !f.char_len_select) return ASYNC_BITS8;
		return ASYNC_BITS7;
	endfunction : sfc_data_len

	// parity or address bit present after the data bits
	function automatic logic sfc_has_extra(input sfc_fmt_t f);
		return !f.sync_mode && (f.parity_on || f.addressed_frame_format);
	endfunction : sfc_has_extra
endpackage : sfc_pkg

// ==== sfc_prescaler.sv ====
// prescaler that feeds the rate generator with clk, clk/4, clk/16 or clk/64 enables
`timescale 1ns/1ps
module sfc_prescaler import sfc_pkg::*; (
	input wire logic clk_sys_in,
	input wire logic rst_in,
	input wire logic [1:0] sel_in,
	output logic tick_out
);
	typedef struct packed {
		logic [5:0] cnt;
		logic tick;
	} sfc_ps_state_t;

	sfc_ps_state_t q;
	sfc_ps_state_t d;
	logic [5:0] mask;

	always_comb begin
		d = q;
		case (sel_in)
			2'h0: mask = PS_MASK_1;
			2'h1: mask = PS_MASK_4;
			2'h2: mask = PS_MASK_16;
			default: mask = PS_MASK_64;
		endcase
		d.cnt = q.cnt + 6'h01;
		d.tick = ((q.cnt & mask) == mask); // [RL9]
	end

	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign tick_out = q.tick;
endmodule : sfc_prescaler

// ==== sfc_rate_gen.sv ====
// divides the prescaled enable by (rate + 1) into the sample enable
`timescale 1ns/1ps
module sfc_rate_gen #(
	parameter int CNT_W = 8
) (
	input wire logic clk_sys_in,
	input wire logic rst_in,
	input wire logic tick_in,
	input wire logic [CNT_W-1:0] rate_in,
	output logic samp_out
);
	typedef struct packed {
		logic [CNT_W-1:0] cnt;
		logic samp;
	} sfc_rg_state_t;

	sfc_rg_state_t q;
	sfc_rg_state_t d;

	if (CNT_W < 1 || CNT_W > 16) begin : g_bad_width
		$error("sfc_rate_gen: CNT_W out of range");
	end

	always_comb begin
		d = q;
		d.samp = 1'b0;
		if (tick_in) begin
			if (q.cnt >= rate_in) begin
				d.cnt = '0;
				d.samp = 1'b1;
			end else begin
				d.cnt = q.cnt + 1'b1;
			end
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign samp_out = q.samp;
endmodule : sfc_rate_gen

// ==== sfc_remote_station.sv ====
// behavioural remote serial station facing the serial port's line pins
`timescale 1ns/1ps
module sfc_remote_station (
	input wire logic clk_sys_in,
	input wire logic txd_in,
	input wire logic sck_in,
	input wire logic [15:0] bit_clks_in,
	output logic rxd_out,
	output logic [23:0] line_bits_out,
	output logic [4:0] line_cnt_out,
	output logic [7:0] sync_bits_out,
	output logic [4:0] sync_edges_out
);
	logic armed;
	logic sck_seen;

	task automatic arm();
		line_bits_out = '1;
		line_cnt_out = '0;
		sync_edges_out = '0;
		armed = 1'b1;
	endtask : arm

	// frames go out back to back, so a second stop bit slot may already hold a start bit
	task automatic send(input logic [23:0] bits, input int n);
		for (int i = 0; i < n; i++) begin
			rxd_out <= bits[i];
			repeat (bit_clks_in) @(posedge clk_sys_in);
		end
		rxd_out <= 1'b1;
	endtask : send

	////////////////////////////////////////////////////////////////////////////////
	// sampling on the falling edge keeps clear of the registered line changes
	initial begin
		rxd_out = 1'b1;
		armed = 1'b0;
		line_bits_out = '1;
		line_cnt_out = '0;
		sync_bits_out = '0;
		sync_edges_out = '0;
		forever begin
			@(negedge clk_sys_in);
			if (armed && txd_in === 1'b0) begin
				armed = 1'b0;
				repeat (bit_clks_in / 16'h0002) @(negedge clk_sys_in);
				for (int i = 0; i < 24; i++) begin
					line_bits_out[i] = txd_in;
					line_cnt_out = 5'(i + 1);
					repeat (bit_clks_in) @(negedge clk_sys_in);
				end
			end
		end
	end

	always @(negedge clk_sys_in) begin
		sck_seen <= sck_in;
		if (sck_in === 1'b1 && sck_seen === 1'b0) begin
			sync_bits_out <= {txd_in, sync_bits_out[7:1]};
			sync_edges_out <= sync_edges_out + 5'h01;
		end
	end
endmodule : sfc_remote_station

// ==== sfc_serial_port_test.sv ====
// self-checking bench for the serial port: registers, frames, prescaler, interrupts
`timescale 1ns/1ps
module sfc_serial_port_test import sfc_pkg::*; ();
	logic clk_sys_in, rst_in, low_power, rd_s, wr_s, txd, rxd, sck_out, sck_oe;
	logic irq_tx, irq_rx, irq_err, wreq;
	logic [4:0] addr;
	logic [31:0] wdata, rdata;
	logic [3:0] be;
	logic [15:0] bit_clks;
	logic [23:0] line_bits;
	logic [4:0] line_cnt, sync_edges;
	logic [7:0] sync_bits, q;
	int err_count, checks_done;
	int cycles = 0;
	// rows: format, first character, second character
	logic [23:0] rows [7] = '{24'h005ac3, 24'h40d581, 24'h201301, 24'h301307,
		24'h287e01, 24'h38960f, 24'h740b80};
	logic [12:0] regs [7] = '{{OFS_FMT, 8'h00}, {OFS_RATE, 8'hff}, {OFS_CTL, 8'h00},
		{OFS_TXH, 8'hff}, {OFS_FLAGS, 8'h84}, {OFS_RXH, 8'h00}, {5'h18, 8'h00}};

	initial begin
		clk_sys_in = 1'b0;
		forever #2.5 clk_sys_in = ~clk_sys_in;
	end

	sfc_serial_port i_dut (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .low_power_in(low_power),
		.avs_address_in(addr), .avs_read_in(rd_s), .avs_write_in(wr_s),
		.avs_writedata_in(wdata), .avs_byteenable_in(be), .avs_readdata_out(rdata),
		.avs_waitrequest_out(wreq), .rxd_in(rxd), .txd_out(txd), .sck_pin_in(sck_out),
		.sck_pin_out(sck_out), .sck_pin_oe_out(sck_oe), .tx_empty_irq_out(irq_tx),
		.rx_full_irq_out(irq_rx), .rx_error_irq_out(irq_err));

	sfc_remote_station i_rs (.clk_sys_in(clk_sys_in), .txd_in(txd), .sck_in(sck_out),
		.bit_clks_in(bit_clks), .rxd_out(rxd), .line_bits_out(line_bits),
		.line_cnt_out(line_cnt), .sync_bits_out(sync_bits), .sync_edges_out(sync_edges));

	////////////////////////////////////////////////////////////////////////////////
	task automatic conclude();
		$display("checks %0d mismatches %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : conclude

	task automatic chk(input string name, input logic [23:0] e, input logic [23:0] g);
		checks_done++;
		if (g !== e) begin
			err_count++;
			$display("[ERR] %s expected %h seen %h", name, e, g);
		end
	endtask : chk

	// request held until waitrequest is sampled low, then released
	// only the bench timeout ends a wait that never gets an answer
	task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d);
		@(posedge clk_sys_in);
		addr <= a;
		wdata <= {24'h000000, d};
		wr_s <= w;
		rd_s <= !w;
		do begin
			@(posedge clk_sys_in);
		end while (wreq !== 1'b0);
		q = rdata[7:0];
		rd_s <= 1'b0;
		wr_s <= 1'b0;
		if (!w) chk("read upper bits", 24'h0, rdata[31:8]);
	endtask : bus

	task automatic rd(input logic [4:0] a);
		bus(1'b0, a, 8'h00);
	endtask : rd

	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		bus(1'b1, a, d);
	endtask : wr

	task automatic clr_tx_holding_empty();
		rd(OFS_FLAGS);
		wr(OFS_FLAGS, q & 8'h7f);
	endtask : clr_tx_holding_empty

	task automatic wait_flag(input int b);
		int n;
		n = 0;
		do begin
			rd(OFS_FLAGS);
			n++;
		end while (q[b] !== 1'b1 && n < 2000);
	endtask : wait_flag

	task automatic idle(input int n);
		repeat (n) @(posedge clk_sys_in);
	endtask : idle

	function automatic logic [23:0] tx_stream(input logic [7:0] f, input logic [7:0] c0,
		input logic [7:0] c1);
		logic [23:0] s;
		logic [7:0] c;
		int p;
		s = '1;
		p = 0;
		for (int k = 0; k < 2; k++) begin
			c = (k == 0) ? c0 : c1;
			if (f[6]) c[7] = 1'b0;
			s[p] = 1'b0;
			p++;
			for (int i = 0; i < (f[6] ? 7 : 8); i++) begin
				s[p] = c[i];
				p++;
			end
			if (f[2] || f[5]) begin
				s[p] = f[2] ? 1'b0 : (^c ^ f[4]);
				p++;
			end
			p += f[3] ? 2 : 1;
		end
		return s;
	endfunction : tx_stream

	function automatic logic [10:0] rx_frame(input logic [7:0] c, input logic o, input logic bad);
		return {1'b1, ^c ^ o ^ bad, c, 1'b0};
	endfunction : rx_frame

	always @(posedge clk_sys_in) begin
		cycles <= cycles + 1;
		if (cycles == 80000) begin
			err_count++;
			conclude();
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		int n, p;
		rst_in = 1'b1;
		low_power = 1'b0;
		rd_s = 1'b0;
		wr_s = 1'b0;
		addr = '0;
		wdata = '0;
		be = 4'h1;
		bit_clks = 16'h0010;
		err_count = 0;
		checks_done = 0;
		idle(4);
		rst_in <= 1'b0;
		for (int i = 0; i < 7; i++) begin
			rd(regs[i][12:8]);
			chk("reset value", 24'(regs[i][7:0]), 24'(q));
		end
		be <= 4'h0;
		wr(OFS_CTL, 8'hff);
		be <= 4'h1;
		rd(OFS_CTL);
		chk("masked write", 24'h0, 24'(q));
		wr(OFS_CTL, 8'h5c);
		rd(OFS_CTL);
		chk("ctl readback", 24'h5c, 24'(q));
		low_power <= 1'b1;
		idle(3);
		low_power <= 1'b0;
		rd(OFS_CTL);
		chk("ctl after stop", 24'h0, 24'(q));
		wr(OFS_CTL, 8'h5c);
		rst_in <= 1'b1;
		idle(4);
		rst_in <= 1'b0;
		rd(OFS_CTL);
		chk("ctl after reset", 24'h0, 24'(q));
		$display("done: registers");
		wr(OFS_RATE, 8'h00);
		foreach (rows[r]) begin
			wr(OFS_CTL, 8'h00);
			wr(OFS_FMT, rows[r][23:16]);
			wr(OFS_CTL, 8'h20);
			i_rs.arm();
			wr(OFS_TXH, rows[r][15:8]);
			clr_tx_holding_empty();
			wait_flag(7);
			wr(OFS_TXH, rows[r][7:0]);
			clr_tx_holding_empty();
			n = 0;
			while (line_cnt !== 5'd24 && n < 3000) begin
				idle(1);
				n++;
			end
			chk("frame bits", tx_stream(rows[r][23:16], rows[r][15:8], rows[r][7:0]),
				line_bits);
		end
		$display("done: frame formats");
		for (int s = 0; s < 4; s++) begin
			wr(OFS_CTL, 8'h00);
			wr(OFS_FMT, {6'h00, s[1:0]});
			wr(OFS_CTL, 8'h20);
			wr(OFS_TXH, 8'h01);
			clr_tx_holding_empty();
			n = 0;
			while (txd !== 1'b0 && n < 2000) begin
				idle(1);
				n++;
			end
			n = 0;
			while (txd === 1'b0 && n < 20000) begin
				idle(1);
				n++;
			end
			p = 1 << (2 * s);
			chk("start bit length", 24'h1, 24'(n > 15 * p && n <= 16 * p));
		end
		$display("done: prescaler");
		wr(OFS_CTL, 8'h00);
		wr(OFS_FMT, 8'hfc);
		i_rs.arm();
		wr(OFS_CTL, 8'h20);
		wr(OFS_TXH, 8'h5a);
		clr_tx_holding_empty();
		n = 0;
		while (sync_edges !== 5'd8 && n < 500) begin
			idle(1);
			n++;
		end
		idle(64);
		chk("sync clock edges", 24'h8, 24'(sync_edges));
		chk("sync data", 24'h5a, 24'(sync_bits));
		chk("clock drive", 24'h1, 24'(sck_oe));
		$display("done: clocked synchronous");
		wr(OFS_CTL, 8'h00);
		wr(OFS_FMT, 8'h00);
		clr_tx_holding_empty();
		idle(4);
		rd(OFS_FLAGS);
		chk("empty held", 24'h1, 24'(q[7]));
		chk("line idle", 24'h1, 24'(txd));
		wr(OFS_CTL, 8'ha0);
		idle(2);
		chk("tx irq", 24'h1, 24'(irq_tx));
		wr(OFS_TXH, 8'h3c);
		clr_tx_holding_empty();
		wait_flag(7);
		wr(OFS_TXH, 8'hc3);
		clr_tx_holding_empty();
		idle(2);
		chk("tx irq cleared", 24'h0, 24'(irq_tx));
		n = 0;
		while (irq_tx !== 1'b1 && n < 1000) begin
			idle(1);
			n++;
		end
		chk("tx irq reload", 24'h1, 24'(irq_tx));
		wr(OFS_CTL, 8'h20);
		idle(2);
		chk("tx irq off", 24'h0, 24'(irq_tx));
		$display("done: transmit interrupt");
		for (int o = 0; o < 2; o++) begin
			wr(OFS_CTL, 8'h00);
			wr(OFS_FMT, {3'b001, o[0], 4'h8});
			wr(OFS_CTL, 8'h50);
			fork
				i_rs.send({2'b11, rx_frame(8'h3d, o[0], 1'b1), rx_frame(8'h3c, o[0], 1'b0)}, 22);
				begin
					wait_flag(6);
					rd(OFS_RXH);
					chk("rx first", 24'h3c, 24'(q));
					rd(OFS_FLAGS);
					chk("no parity error", 24'h0, 24'(q[3]));
					wr(OFS_FLAGS, q & 8'hbf);
				end
			join
			wait_flag(6);
			rd(OFS_RXH);
			chk("rx second", 24'h3d, 24'(q));
			rd(OFS_FLAGS);
			chk("parity error", 24'h1, 24'(q[3]));
			idle(2);
			chk("rx irq", 24'h1, 24'(irq_rx));
			chk("err irq", 24'h1, 24'(irq_err));
			wr(OFS_CTL, 8'h40);
			rd(OFS_FLAGS);
			chk("flags kept", 24'h48, 24'(q & 8'h78));
			wr(OFS_FLAGS, q & 8'hf7);
			idle(2);
			chk("err irq gone", 24'h0, 24'(irq_err));
			chk("rx irq kept", 24'h1, 24'(irq_rx));
			wr(OFS_CTL, 8'h00);
			idle(2);
			chk("rx irq off", 24'h0, 24'(irq_rx));
			rd(OFS_FLAGS);
			wr(OFS_FLAGS, 8'h00);
		end
		$display("done: receive");
		wr(OFS_CTL, 8'h00);
		wr(OFS_FMT, 8'h80);
		wr(OFS_CTL, 8'h10);
		wait_flag(6);
		rd(OFS_RXH);
		chk("sync rx", 24'hff, 24'(q));
		$display("done: synchronous receive");
		conclude();
	end
endmodule : sfc_serial_port_test
